// ===== src/bav_top.sv
// Operation
// - Adaptive disabled: output voltage held at the initial-voltage setting.
// - Adaptive enabled: start at initial voltage, then follow highest string voltage.
// - All outputs in cluster mode forces adaptive mode off.
// - Jump enable clear uses normal steps only; set allows jump commands.
// - Threshold codes 00..11 trigger jumps at 10, 30, 50, 70 percent rise.
// - Jump step codes 00..11 add 8, 16, 32, 64 control steps.
// - Initial code maps to 16 V plus 0.5 V per code, up to 47.5 V.
// - Jitter filter codes: bypass, 300 kHz, 60 kHz, 30 kHz.
// - Bits 3:2 select integral gain 1 to 4.
// - Bits 1:0 select proportional gain 1 to 4.
// - Light-load codes select PFM entry threshold 5, 10, 15, 20 uA.
// - Driver-size field selects one of four gate driver strengths.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "bav_map.svh"

module bav_top
  import bav_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  cluster_mode,
  input  wire logic        step_tick,
  input  wire logic        headroom_low,
  input  wire logic        headroom_high,
  input  wire logic [15:0] brightness,
  input  wire logic        brightness_valid,
  output logic      [7:0]  boost_target,
  output logic             adapt_active,
  output logic             jump_pulse,
  output logic             jitter_bypass,
  output logic      [1:0]  jitter_corner,
  output logic      [2:0]  int_gain,
  output logic      [2:0]  prop_gain,
  output logic      [4:0]  pfm_threshold_ua,
  output logic      [1:0]  driver_strength
);

  bav_cfg_if  cfg ();
  bav_state_t state;
  bav_state_t next_state;
  logic [7:0] next_boost_target;
  logic       next_jump_pulse;
  logic [7:0] start_steps;
  logic       adapt_allowed;
  logic       leap_evt;
  logic       next_jitter_bypass;
  logic [2:0] next_int_gain;
  logic [2:0] next_prop_gain;
  logic [4:0] next_pfm_threshold_ua;

  // Control steps for a jump size code
  function automatic logic [6:0] jump_steps(input logic [1:0] code);
    case (code)
      2'h0:    jump_steps = `BAV_JUMP_STEPS_0;
      2'h1:    jump_steps = `BAV_JUMP_STEPS_1;
      2'h2:    jump_steps = `BAV_JUMP_STEPS_2;
      default: jump_steps = `BAV_JUMP_STEPS_3;
    endcase
  endfunction

  // Saturating addition to the voltage target
  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [6:0] b);
    logic [8:0] sum;
    sum = {1'b0, a} + {2'b00, b};
    if (sum > {1'b0, `BAV_TARGET_MAX}) begin
      sat_add = `BAV_TARGET_MAX;
    end else begin
      sat_add = sum[7:0];
    end
  endfunction

  bav_apb_regs u_regs (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .cfg     (cfg)
  );

  bav_leap_detect u_leap (
    .pclk             (pclk),
    .presetn          (presetn),
    .brightness       (brightness),
    .brightness_valid (brightness_valid),
    .thr_code         (cfg.leap_trigger_threshold),
    .leap_evt         (leap_evt)
  );

  // Initial voltage in control steps; 0.5 V per code is four steps
  assign start_steps   = {2'b00, cfg.init_volt} << `BAV_STEPS_PER_CODE;
  assign adapt_allowed = cfg.adapt_en && !(&cluster_mode);

  // Voltage target control
  always_comb begin
    next_state        = state;
    next_boost_target = boost_target;
    next_jump_pulse   = 1'b0;
    case (state)
      BAV_FIXED: begin
        next_boost_target = start_steps;
        if (adapt_allowed) begin
          next_state = BAV_ADAPT;
        end
      end
      BAV_ADAPT: begin
        if (!adapt_allowed) begin
          next_state        = BAV_FIXED;
          next_boost_target = start_steps;
        end else if (cfg.jump_en && leap_evt) begin
          next_boost_target = sat_add(boost_target, jump_steps(cfg.jump_step));
          next_jump_pulse   = 1'b1;
        end else if (step_tick && headroom_low) begin
          next_boost_target = sat_add(boost_target, 7'h01);
        end else if (step_tick && headroom_high && (boost_target != 8'h00)) begin
          next_boost_target = boost_target - 8'h01;
        end
      end
      default: begin
        next_state        = BAV_FIXED;
        next_boost_target = start_steps;
      end
    endcase
  end

  // Target and state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= BAV_FIXED;
      boost_target <= 8'h00;
      adapt_active <= 1'b0;
      jump_pulse   <= 1'b0;
    end else begin
      state        <= next_state;
      boost_target <= next_boost_target;
      adapt_active <= (next_state == BAV_ADAPT);
      jump_pulse   <= next_jump_pulse;
    end
  end

  // Loop tuning decode
  always_comb begin
    next_jitter_bypass    = (cfg.jitter == 2'h0);
    next_int_gain         = {1'b0, cfg.gain_i} + 3'h1;
    next_prop_gain        = {1'b0, cfg.gain_p} + 3'h1;
    next_pfm_threshold_ua = 5'(({3'h0, cfg.light_load_threshold} + 5'h01) * `BAV_PFM_UA_STEP);
  end

  // Tuning output registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jitter_bypass    <= 1'b1;
      jitter_corner    <= 2'h0;
      int_gain         <= 3'h1;
      prop_gain        <= 3'h1;
      pfm_threshold_ua <= 5'h05;
      driver_strength  <= 2'h0;
    end else begin
      jitter_bypass    <= next_jitter_bypass;
      jitter_corner    <= cfg.jitter;
      int_gain         <= next_int_gain;
      prop_gain        <= next_prop_gain;
      pfm_threshold_ua <= next_pfm_threshold_ua;
      driver_strength  <= cfg.driver_size;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_fixed_hold;
    (state == BAV_FIXED) |=> (boost_target == $past(start_steps));
  endproperty
  a_fixed_hold: assert property (p_fixed_hold) else $error("fixed target wrong");

  property p_adapt_start;
    $rose(adapt_active) |-> (boost_target == $past(start_steps));
  endproperty
  a_adapt_start: assert property (p_adapt_start) else $error("adaptive start wrong");

  property p_cluster_off;
    (&cluster_mode) |=> !adapt_active;
  endproperty
  a_cluster_off: assert property (p_cluster_off) else $error("cluster mode kept adapt");

  property p_no_jump;
    !cfg.jump_en |=> !jump_pulse;
  endproperty
  a_no_jump: assert property (p_no_jump) else $error("jump while disabled");

  property p_jump_add;
    jump_pulse |-> boost_target == sat_add($past(boost_target), jump_steps($past(cfg.jump_step)));
  endproperty
  a_jump_add: assert property (p_jump_add) else $error("jump size wrong");

  property p_target_max;
    boost_target <= `BAV_TARGET_MAX;
  endproperty
  a_target_max: assert property (p_target_max) else $error("target above maximum");

  property p_step_change;
    adapt_active && $past(adapt_active) && !jump_pulse && $past(adapt_allowed)
      |-> (boost_target - $past(boost_target) == 8'h01) || (boost_target == $past(boost_target))
          || ($past(boost_target) - boost_target == 8'h01);
  endproperty
  a_step_change: assert property (p_step_change) else $error("normal step too large");

  property p_gains;
    ##1 (prop_gain == {1'b0, $past(cfg.gain_p)} + 3'h1)
        && (int_gain == {1'b0, $past(cfg.gain_i)} + 3'h1);
  endproperty
  a_gains: assert property (p_gains) else $error("gain decode wrong");

  property p_pfm;
    ##1 pfm_threshold_ua == 5'(({3'h0, $past(cfg.light_load_threshold)} + 5'h01) * 5'h05);
  endproperty
  a_pfm: assert property (p_pfm) else $error("pfm threshold wrong");

  property p_jitter;
    ##1 (jitter_bypass == ($past(cfg.jitter) == 2'h0)) && (driver_strength == $past(cfg.driver_size));
  endproperty
  a_jitter: assert property (p_jitter) else $error("jitter or driver decode wrong");

  // Adaptive state entry and exit
  property p_adapt_enter;
    adapt_allowed |=> adapt_active;
  endproperty
  a_adapt_enter: assert property (p_adapt_enter) else $error("adaptive entry missed");

  property p_adapt_leave;
    !adapt_allowed |=> !adapt_active;
  endproperty
  a_adapt_leave: assert property (p_adapt_leave) else $error("adaptive kept when off");

  property p_leave_target;
    (state == BAV_ADAPT) && !adapt_allowed |=> boost_target == $past(start_steps);
  endproperty
  a_leave_target: assert property (p_leave_target) else $error("target not restored");

  // Normal adaptive steps
  property p_step_up;
    (state == BAV_ADAPT) && adapt_allowed && !(cfg.jump_en && leap_evt) && step_tick
      && headroom_low && (boost_target < `BAV_TARGET_MAX)
      |=> boost_target == $past(boost_target) + 8'h01;
  endproperty
  a_step_up: assert property (p_step_up) else $error("step up missed");

  property p_step_down;
    (state == BAV_ADAPT) && adapt_allowed && !(cfg.jump_en && leap_evt) && step_tick
      && !headroom_low && headroom_high && (boost_target != 8'h00)
      |=> boost_target == $past(boost_target) - 8'h01;
  endproperty
  a_step_down: assert property (p_step_down) else $error("step down missed");

  property p_no_wrap;
    boost_target == 8'h00 |=> boost_target != 8'hFF;
  endproperty
  a_no_wrap: assert property (p_no_wrap) else $error("target wrapped below zero");

  // Jump origin
  property p_jump_cause;
    jump_pulse |-> $past(leap_evt) && $past(cfg.jump_en);
  endproperty
  a_jump_cause: assert property (p_jump_cause) else $error("jump without cause");

  property p_jump_adapt;
    jump_pulse |-> $past(state) == BAV_ADAPT;
  endproperty
  a_jump_adapt: assert property (p_jump_adapt) else $error("jump outside adaptive");

  // Tuning ranges
  property p_corner;
    ##1 jitter_corner == $past(cfg.jitter);
  endproperty
  a_corner: assert property (p_corner) else $error("jitter corner wrong");

  property p_gain_range;
    (int_gain != 3'h0) && (int_gain <= 3'h4) && (prop_gain != 3'h0) && (prop_gain <= 3'h4);
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("gain out of range");

  c_adapt_enter: cover property ($rose(adapt_active));
  c_jump:        cover property (jump_pulse);
  c_saturate:    cover property (jump_pulse && boost_target == `BAV_TARGET_MAX);
  c_cluster:     cover property (cfg.adapt_en && (&cluster_mode));
  c_leave:       cover property ($fell(adapt_active));

endmodule

`default_nettype wire

// ===== src/bav_map.svh
`ifndef BAV_MAP_SVH
`define BAV_MAP_SVH

// Register indices; byte address is four times the index
`define BAV_IDX_JUMP_CFG     8'h72
`define BAV_IDX_START_VOLT   8'h73
`define BAV_IDX_LOOP_TUNING  8'h74

// Reset values
`define BAV_RST_JUMP_CFG     8'h00
`define BAV_RST_START_VOLT   8'h00
`define BAV_RST_LOOP_TUNING  8'h00

// Adaptive and jump configuration fields
`define BAV_DRV_SIZE_MSB     7
`define BAV_DRV_SIZE_LSB     6
`define BAV_ADAPT_EN_BIT     5
`define BAV_JUMP_EN_BIT      4
`define BAV_LEAP_THR_MSB     3
`define BAV_LEAP_THR_LSB     2
`define BAV_JUMP_STEP_MSB    1
`define BAV_JUMP_STEP_LSB    0

// Start voltage field
`define BAV_INIT_VOLT_MSB    5
`define BAV_INIT_VOLT_LSB    0
`define BAV_START_VOLT_MASK  8'h3F

// Loop tuning fields
`define BAV_LLC_MSB          7
`define BAV_LLC_LSB          6
`define BAV_JITTER_MSB       5
`define BAV_JITTER_LSB       4
`define BAV_GAIN_I_MSB       3
`define BAV_GAIN_I_LSB       2
`define BAV_GAIN_P_MSB       1
`define BAV_GAIN_P_LSB       0

// Voltage target in control steps of 0.125 V above 16 V
`define BAV_STEPS_PER_CODE   2
`define BAV_TARGET_MAX       8'hFC

// Jump sizes in control steps
`define BAV_JUMP_STEPS_0     7'h08
`define BAV_JUMP_STEPS_1     7'h10
`define BAV_JUMP_STEPS_2     7'h20
`define BAV_JUMP_STEPS_3     7'h40

// Brightness rise thresholds: 10, 30, 50 and 70 percent of full scale
`define BAV_LEAP_THR_0       17'h0199A
`define BAV_LEAP_THR_1       17'h04CCD
`define BAV_LEAP_THR_2       17'h08000
`define BAV_LEAP_THR_3       17'h0B333

// Light-load threshold step in microamps
`define BAV_PFM_UA_STEP      3'h5

`endif

// ===== src/bav_pkg.sv
package bav_pkg;

  // Voltage control state
  typedef enum logic [0:0] {
    BAV_FIXED = 1'b0,
    BAV_ADAPT = 1'b1
  } bav_state_t;

  // Apb slave access phase
  typedef enum logic [0:0] {
    BAV_APB_WAIT = 1'b0,
    BAV_APB_DONE = 1'b1
  } bav_apb_t;

endpackage

// ===== src/bav_cfg_if.sv
`timescale 1ns/1ns
`default_nettype none

// Configuration fields from the register file to the control core
interface bav_cfg_if;
  logic [1:0] driver_size;
  logic       adapt_en;
  logic       jump_en;
  logic [1:0] leap_trigger_threshold;
  logic [1:0] jump_step;
  logic [5:0] init_volt;
  logic [1:0] light_load_threshold;
  logic [1:0] jitter;
  logic [1:0] gain_i;
  logic [1:0] gain_p;

  modport regs (output driver_size, adapt_en, jump_en, leap_trigger_threshold, jump_step,
                init_volt, light_load_threshold, jitter, gain_i, gain_p);
  modport core (input driver_size, adapt_en, jump_en, leap_trigger_threshold, jump_step,
                init_volt, light_load_threshold, jitter, gain_i, gain_p);
endinterface

`default_nettype wire

// ===== src/bav_apb_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "bav_map.svh"

module bav_apb_regs
  import bav_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  bav_cfg_if.regs          cfg
);

  logic [7:0]  jump_cfg;
  logic [7:0]  start_volt;
  logic [7:0]  loop_tuning;
  logic [7:0]  next_jump_cfg;
  logic [7:0]  next_start_volt;
  logic [7:0]  next_loop_tuning;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        access;
  logic        commit;

  // Byte address of a register index
  function automatic logic [11:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction

  // One wait state: answer is prepared in the first access cycle
  always_comb begin
    next_jump_cfg    = jump_cfg;
    next_start_volt  = start_volt;
    next_loop_tuning = loop_tuning;
    next_prdata      = prdata;
    next_pslverr     = pslverr;
    access           = psel & penable & ~pready;
    commit           = psel & penable & pready;
    next_pready      = access;
    if (access) begin
      next_pslverr = 1'b0;
      next_prdata  = 32'h0000_0000;
      if (paddr == byte_addr(`BAV_IDX_JUMP_CFG)) begin
        next_prdata = {24'h00_0000, jump_cfg};
      end else if (paddr == byte_addr(`BAV_IDX_START_VOLT)) begin
        next_prdata = {24'h00_0000, start_volt};
      end else if (paddr == byte_addr(`BAV_IDX_LOOP_TUNING)) begin
        next_prdata = {24'h00_0000, loop_tuning};
      end else begin
        next_pslverr = 1'b1;
      end
    end
    if (commit && pwrite && !pslverr) begin
      if (paddr == byte_addr(`BAV_IDX_JUMP_CFG)) begin
        next_jump_cfg = pwdata[7:0];
      end else if (paddr == byte_addr(`BAV_IDX_START_VOLT)) begin
        next_start_volt = pwdata[7:0] & `BAV_START_VOLT_MASK;  // Reserved bits read zero
      end else if (paddr == byte_addr(`BAV_IDX_LOOP_TUNING)) begin
        next_loop_tuning = pwdata[7:0];
      end
    end
  end

  // Register state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jump_cfg    <= `BAV_RST_JUMP_CFG;
      start_volt  <= `BAV_RST_START_VOLT;
      loop_tuning <= `BAV_RST_LOOP_TUNING;
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
    end else begin
      jump_cfg    <= next_jump_cfg;
      start_volt  <= next_start_volt;
      loop_tuning <= next_loop_tuning;
      prdata      <= next_prdata;
      pready      <= next_pready;
      pslverr     <= next_pslverr;
    end
  end

  // Field outputs
  assign cfg.driver_size            = jump_cfg[`BAV_DRV_SIZE_MSB:`BAV_DRV_SIZE_LSB];
  assign cfg.adapt_en               = jump_cfg[`BAV_ADAPT_EN_BIT];
  assign cfg.jump_en                = jump_cfg[`BAV_JUMP_EN_BIT];
  assign cfg.leap_trigger_threshold = jump_cfg[`BAV_LEAP_THR_MSB:`BAV_LEAP_THR_LSB];
  assign cfg.jump_step              = jump_cfg[`BAV_JUMP_STEP_MSB:`BAV_JUMP_STEP_LSB];
  assign cfg.init_volt              = start_volt[`BAV_INIT_VOLT_MSB:`BAV_INIT_VOLT_LSB];
  assign cfg.light_load_threshold   = loop_tuning[`BAV_LLC_MSB:`BAV_LLC_LSB];
  assign cfg.jitter                 = loop_tuning[`BAV_JITTER_MSB:`BAV_JITTER_LSB];
  assign cfg.gain_i                 = loop_tuning[`BAV_GAIN_I_MSB:`BAV_GAIN_I_LSB];
  assign cfg.gain_p                 = loop_tuning[`BAV_GAIN_P_MSB:`BAV_GAIN_P_LSB];

endmodule

`default_nettype wire

// ===== src/bav_leap_detect.sv
`timescale 1ns/1ns
`default_nettype none
`include "bav_map.svh"

module bav_leap_detect
  import bav_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] brightness,
  input  wire logic        brightness_valid,
  input  wire logic [1:0]  thr_code,
  output logic             leap_evt
);

  logic [15:0] last_level;
  logic [15:0] next_last_level;
  logic        next_leap_evt;
  logic [16:0] rise;

  // Brightness rise needed for a jump
  function automatic logic [16:0] thr_value(input logic [1:0] code);
    case (code)
      2'h0:    thr_value = `BAV_LEAP_THR_0;
      2'h1:    thr_value = `BAV_LEAP_THR_1;
      2'h2:    thr_value = `BAV_LEAP_THR_2;
      default: thr_value = `BAV_LEAP_THR_3;
    endcase
  endfunction

  // Compare each new level with the previous one
  always_comb begin
    rise            = {1'b0, brightness} - {1'b0, last_level};
    next_last_level = last_level;
    next_leap_evt   = 1'b0;
    if (brightness_valid) begin
      next_last_level = brightness;
      next_leap_evt   = (brightness > last_level) && (rise >= thr_value(thr_code));
    end
  end

  // Level memory and event pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_level <= 16'h0000;
      leap_evt   <= 1'b0;
    end else begin
      last_level <= next_last_level;
      leap_evt   <= next_leap_evt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_leap_thr;
    brightness_valid && (brightness > last_level) && (rise >= thr_value(thr_code))
      |=> leap_evt;
  endproperty
  a_leap_thr: assert property (p_leap_thr) else $error("jump threshold not honoured");

  property p_leap_small;
    brightness_valid && (rise < thr_value(thr_code)) |=> !leap_evt;
  endproperty
  a_leap_small: assert property (p_leap_small) else $error("jump below threshold");

endmodule

`default_nettype wire

// ===== testbench/bav_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "bav_map.svh"

module bav_top_bench
  import bav_pkg::*;
;
  // Byte addresses of the three configuration words
  localparam logic [11:0] A_JUMP  = {2'b00, `BAV_IDX_JUMP_CFG, 2'b00};
  localparam logic [11:0] A_START = {2'b00, `BAV_IDX_START_VOLT, 2'b00};
  localparam logic [11:0] A_LOOP  = {2'b00, `BAV_IDX_LOOP_TUNING, 2'b00};

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  cluster_mode;
  logic        step_tick;
  logic        headroom_low;
  logic        headroom_high;
  logic [15:0] brightness;
  logic        brightness_valid;
  logic [7:0]  boost_target;
  logic        adapt_active;
  logic        jump_pulse;
  logic        jitter_bypass;
  logic [1:0]  jitter_corner;
  logic [2:0]  int_gain;
  logic [2:0]  prop_gain;
  logic [4:0]  pfm_threshold_ua;
  logic [1:0]  driver_strength;
  int          error_cnt;
  int          check_count;
  logic [31:0] rd;
  logic        err;
  int          pulses;

  bav_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cluster_mode(cluster_mode), .step_tick(step_tick), .headroom_low(headroom_low),
    .headroom_high(headroom_high), .brightness(brightness),
    .brightness_valid(brightness_valid), .boost_target(boost_target),
    .adapt_active(adapt_active), .jump_pulse(jump_pulse), .jitter_bypass(jitter_bypass),
    .jitter_corner(jitter_corner), .int_gain(int_gain), .prop_gain(prop_gain),
    .pfm_threshold_ua(pfm_threshold_ua), .driver_strength(driver_strength)
  );

  // Clock generator, 4 ns period
  always #2 pclk = ~pclk;

  task automatic tally_and_finish();
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] data);
    apb(1'b1, addr, data);
  endtask

  task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp, input logic experr);
    apb(1'b0, addr, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, experr});
  endtask

  task automatic settle();
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask

  // Single-cycle step request with headroom levels
  task automatic step(input logic lo, input logic hi);
    @(posedge pclk);
    step_tick     <= 1'b1;
    headroom_low  <= lo;
    headroom_high <= hi;
    @(posedge pclk);
    step_tick     <= 1'b0;
    headroom_low  <= 1'b0;
    headroom_high <= 1'b0;
    repeat (3) @(negedge pclk);
  endtask

  // Brightness sample, then count jump pulses that follow it
  task automatic bright(input logic [15:0] val);
    @(posedge pclk);
    brightness       <= val;
    brightness_valid <= 1'b1;
    @(posedge pclk);
    brightness_valid <= 1'b0;
    pulses = 0;
    repeat (6) begin
      @(negedge pclk);
      if (jump_pulse === 1'b1) pulses++;
    end
  endtask

  task automatic t_reset();
    @(negedge pclk);
    chk({24'h0, boost_target}, 32'h0);
    chk({29'h0, adapt_active, jitter_bypass, jump_pulse}, 32'h2);
    chk({26'h0, int_gain, prop_gain}, 32'h9);
    chk({25'h0, pfm_threshold_ua, driver_strength}, 32'h14);
    rdchk(A_JUMP, 32'h0, 1'b0);
    rdchk(A_START, 32'h0, 1'b0);
    rdchk(A_LOOP, 32'h0, 1'b0);
  endtask

  task automatic t_regs();
    wr(A_START, 32'hFFFFFFFF);
    rdchk(A_START, 32'h3F, 1'b0);
    wr(A_LOOP, 32'hFFFFFF5A);
    rdchk(A_LOOP, 32'h5A, 1'b0);
    rdchk(12'h000, 32'h0, 1'b1);
    wr(A_START, 32'h0);
  endtask

  task automatic t_tuning();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(A_LOOP, {24'h0, c, c + 2'h1, c + 2'h2, c + 2'h3});
      wr(A_JUMP, {24'h0, c, 6'h0});
      settle();
      chk({27'h0, pfm_threshold_ua}, 32'(5 * (i + 1)));
      chk({31'h0, jitter_bypass}, {31'h0, (c + 2'h1) == 2'h0});
      chk({30'h0, jitter_corner}, {30'h0, c + 2'h1});
      chk({29'h0, int_gain}, {29'h0, 1'b0, c + 2'h2} + 32'h1);
      chk({29'h0, prop_gain}, {29'h0, 1'b0, c + 2'h3} + 32'h1);
      chk({30'h0, driver_strength}, {30'h0, c});
    end
  endtask

  task automatic t_fixed();
    logic [5:0] codes [4];
    codes = '{6'h00, 6'h01, 6'h2A, 6'h3F};
    wr(A_JUMP, 32'h0);
    foreach (codes[i]) begin
      wr(A_START, {26'h0, codes[i]});
      settle();
      chk({24'h0, boost_target}, {22'h0, codes[i], 2'b00});
      step(1'b1, 1'b0);
      chk({24'h0, boost_target}, {22'h0, codes[i], 2'b00});
      chk({31'h0, adapt_active}, 32'h0);
    end
  endtask

  task automatic t_adapt();
    wr(A_START, 32'h0A);
    wr(A_JUMP, 32'h20);
    settle();
    chk({23'h0, adapt_active, boost_target}, 32'h128);
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
    step(1'b0, 1'b1);
    chk({24'h0, boost_target}, 32'd41);
    @(posedge pclk);
    cluster_mode <= 4'hF;
    settle();
    chk({23'h0, adapt_active, boost_target}, 32'd40);
    @(posedge pclk);
    cluster_mode <= 4'h7;
    settle();
    chk({31'h0, adapt_active}, 32'h1);
    wr(A_JUMP, 32'h0);
    settle();
    chk({23'h0, adapt_active, boost_target}, 32'd40);
  endtask

  task automatic t_jump();
    logic [16:0] thr [4];
    logic [1:0]  c;
    thr = '{`BAV_LEAP_THR_0, `BAV_LEAP_THR_1, `BAV_LEAP_THR_2, `BAV_LEAP_THR_3};
    wr(A_JUMP, 32'h2F);
    bright(16'h0);
    bright(16'hFFFF);
    chk(pulses, 0);
    chk({24'h0, boost_target}, 32'd40);
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(A_JUMP, 32'h0);
      wr(A_JUMP, {24'h0, 4'h3, c, c});
      bright(16'h0);
      bright(thr[i][15:0] - 16'h1);
      chk(pulses, 0);
      bright(16'h0);
      bright(thr[i][15:0]);
      chk(pulses, 1);
      chk({24'h0, boost_target}, 32'd40 + (32'd8 << i));
    end
  endtask

  task automatic t_sat();
    wr(A_START, 32'h3C);
    wr(A_JUMP, 32'h0);
    wr(A_JUMP, 32'h31);
    bright(16'h0);
    bright(16'hFFFF);
    chk(pulses, 1);
    chk({24'h0, boost_target}, 32'hFC);
    bright(16'h0);
    bright(16'hFFFF);
    chk({24'h0, boost_target}, 32'hFC);
  endtask

  // Reset, then the scenarios in turn
  initial begin
    pclk             = 1'b0;
    presetn          = 1'b0;
    psel             = 1'b0;
    penable          = 1'b0;
    pwrite           = 1'b0;
    paddr            = 12'h0;
    pwdata           = 32'h0;
    cluster_mode     = 4'h0;
    step_tick        = 1'b0;
    headroom_low     = 1'b0;
    headroom_high    = 1'b0;
    brightness       = 16'h0;
    brightness_valid = 1'b0;
    error_cnt        = 0;
    check_count      = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_regs();
    t_tuning();
    t_fixed();
    t_adapt();
    t_jump();
    t_sat();
    tally_and_finish();
  end
endmodule

`default_nettype wire
